// *** rtl/shutdown_wakeup_pkg.sv ***
package shutdown_wakeup_pkg;

  localparam logic [11:0] POWER_OFF_COMMAND_OFFSET  = 12'h000;
  localparam logic [11:0] WAKE_CONFIGURATION_OFFSET = 12'h004;
  localparam logic [11:0] WAKE_STATUS_OFFSET        = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFFSET           = 12'h00c;

  localparam logic [7:0]  POWER_OFF_KEY       = 8'ha5;
  localparam int          KEY_LSB             = 24;
  localparam int          POWER_OFF_CMD_BIT   = 0;

  localparam int          WAKE_EDGE_LSB       = 0;
  localparam int          WAKE_DEBOUNCE_LSB   = 4;
  localparam int          TIMER_WAKE_EN_BIT   = 16;
  localparam int          CLOCK_WAKE_EN_BIT   = 17;
  localparam logic [31:0] WAKE_CONFIG_RESET   = 32'h0000_0003;

  localparam int          WAKE_FLAG_BIT       = 0;
  localparam int          TIMER_FLAG_BIT      = 16;
  localparam int          CLOCK_FLAG_BIT      = 17;

  localparam int          DEBOUNCE_UNIT       = 16;
  localparam int          POWER_OFF_DELAY     = 2;

  typedef enum logic [1:0] {
    EDGE_NONE    = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_ANY     = 2'b11
  } wake_edge_t;

endpackage

// *** rtl/shutdown_wakeup_controller.sv ***
// Notes on behaviour
// RULE1: Keyed write with command bit 1 asserts power-off output; bit 0 does nothing.
// RULE2: Power-off reaches the output pin two slow clock cycles after the write.
// RULE3: Key field must be 0xA5; any other key discards the whole write.
// RULE4: Block runs on the slow clock continuously, no clock gating.
// RULE5: Wake detector reacts to rising, falling, any change, or nothing.
// RULE6: Edge select 00 none, 01 rising, 10 falling, 11 any change.
// RULE7: Wake pulses shorter than debounce count times 16 cycles are ignored.
// RULE8: Selected transition starts counter; reaching debounce value releases power-off.
// RULE9: Any new wake input change before completion stops and clears the counter; a change that is a selected edge restarts it from zero.
// RULE10: Release comes debounce count times 16 plus 1 cycles after the event.
// RULE11: Each wake input event sets sticky flag, cleared by status read; the code sets it only when a selected edge completes the debounce.
// RULE12: Enabled timer alarm rising edge, synchronised, releases power-off.
// RULE13: Timer alarm wake sets sticky flag, cleared by status read.
// RULE14: Enabled clock alarm rising edge, synchronised, releases power-off.
// RULE15: Clock alarm wake sets sticky flag, cleared by status read.
// RULE16: Software clears alarm status before power-off, else no wake edge.
// RULE17: Disabled alarm wake enables make the alarms ineffective.
// RULE18: Once released, power-off stays low until another valid command.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module shutdown_wakeup_controller
  import shutdown_wakeup_pkg::*;
#(
  parameter int DEBOUNCE_W = 4
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        wake_in0_i,
  input  wire logic        timer_alarm_i,
  input  wire logic        clock_alarm_i,
  output logic             power_off_out_o,
  output logic             irq_o
);

  localparam int CNT_W = DEBOUNCE_W + 5;

  typedef struct packed {
    // Pin synchronisers and previous levels
    logic [1:0]            wake_sync;
    logic                  wake_prev;
    logic [1:0]            timer_sync;
    logic                  timer_prev;
    logic [1:0]            clock_sync;
    logic                  clock_prev;
    // Debounce counter
    logic                  counting;
    logic [CNT_W-1:0]      count;
    // Command delay and pin level
    logic [POWER_OFF_DELAY-1:0] cmd_pipe;
    logic                  power_off;
    // Software configuration
    wake_edge_t            edge_sel;
    logic [DEBOUNCE_W-1:0] debounce;
    logic                  timer_en;
    logic                  clock_en;
    logic [2:0]            irq_mask;
    // Sticky flags and bus read state
    logic                  wake_flag;
    logic                  timer_flag;
    logic                  clock_flag;
    logic                  access_phase;
    logic [31:0]           rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic              access;
  logic              wr;
  logic              rd;
  logic              addr_ok;
  logic              key_ok;
  logic              cmd_wr;
  logic              cfg_wr;
  logic              mask_wr;
  logic              status_rd;
  logic              wake_rise;
  logic              wake_fall;
  logic              wake_change;
  logic              wake_hit;
  logic              wake_done;
  logic              timer_rise;
  logic              clock_rise;
  logic              timer_hit;
  logic              clock_hit;
  logic              release_now;
  logic [CNT_W-1:0]  target;
  logic [31:0]       config_word;
  logic [31:0]       status_word;
  logic [2:0]        flags;

  // Register bus decode; pready is always high, so an access completes at once
  assign access  = psel_i && penable_i;
  assign addr_ok = (paddr_i == POWER_OFF_COMMAND_OFFSET)
                || (paddr_i == WAKE_CONFIGURATION_OFFSET)
                || (paddr_i == WAKE_STATUS_OFFSET)
                || (paddr_i == IRQ_MASK_OFFSET);
  assign wr      = access && pwrite_i && addr_ok;
  assign rd      = access && !pwrite_i && addr_ok;

  // RULE3 key gates the whole command write
  assign key_ok    = (pwdata_i[KEY_LSB +: 8] == POWER_OFF_KEY);
  // RULE1 command bit and both lanes
  assign cmd_wr    = wr && (paddr_i == POWER_OFF_COMMAND_OFFSET) && key_ok
                  && pwdata_i[POWER_OFF_CMD_BIT] && pstrb_i[3] && pstrb_i[0];
  assign cfg_wr    = wr && (paddr_i == WAKE_CONFIGURATION_OFFSET);
  assign mask_wr   = wr && (paddr_i == IRQ_MASK_OFFSET) && pstrb_i[0];
  // Flags clear on the edge that completes the read
  assign status_rd = rd && (paddr_i == WAKE_STATUS_OFFSET);

  // Edge detection on synchronised wake input
  assign wake_rise   = state_reg.wake_sync[1] && !state_reg.wake_prev;
  assign wake_fall   = !state_reg.wake_sync[1] && state_reg.wake_prev;
  assign wake_change = wake_rise || wake_fall;

  always_comb begin
    // RULE5 RULE6 edge selection
    unique case (state_reg.edge_sel)
      EDGE_NONE:    wake_hit = 1'b0;
      EDGE_RISING:  wake_hit = wake_rise;
      EDGE_FALLING: wake_hit = wake_fall;
      EDGE_ANY:     wake_hit = wake_change;
    endcase
  end

  // RULE7 RULE10 debounce target in slow clock cycles
  assign target = CNT_W'(state_reg.debounce) * CNT_W'(DEBOUNCE_UNIT);
  // RULE8 counter reaches programmed value
  assign wake_done = state_reg.counting && !wake_change && (state_reg.count >= target);

  // Alarm edges seen on the second synchroniser stage
  assign timer_rise = state_reg.timer_sync[1] && !state_reg.timer_prev;
  assign clock_rise = state_reg.clock_sync[1] && !state_reg.clock_prev;

  // RULE12 RULE17 gated timer alarm edge
  assign timer_hit = state_reg.timer_en && timer_rise;
  // RULE14 RULE17 gated clock alarm edge
  assign clock_hit = state_reg.clock_en && clock_rise;

  // Any enabled source releases the pin
  assign release_now = wake_done || timer_hit || clock_hit;

  // Config: edge select, debounce count, alarm enables
  assign config_word = {14'h0000, state_reg.clock_en, state_reg.timer_en,
                        {(12 - DEBOUNCE_W){1'b0}}, state_reg.debounce,
                        2'b00, state_reg.edge_sel};
  // Status: wake flag in bit 0, alarm flags in bits 16 and 17
  assign status_word = {14'h0000, state_reg.clock_flag, state_reg.timer_flag,
                        15'h0000, state_reg.wake_flag};
  // Interrupt sources in the mask register's bit order
  assign flags       = {state_reg.clock_flag, state_reg.timer_flag, state_reg.wake_flag};

  always_comb begin
    state_next = state_reg;
    // RULE4 input synchronisers on the free running slow clock
    // Two flops per pin; only the second stage feeds any logic
    state_next.wake_sync  = {state_reg.wake_sync[0], wake_in0_i};
    state_next.wake_prev  = state_reg.wake_sync[1];

    state_next.timer_sync = {state_reg.timer_sync[0], timer_alarm_i};
    state_next.timer_prev = state_reg.timer_sync[1];

    state_next.clock_sync = {state_reg.clock_sync[0], clock_alarm_i};
    state_next.clock_prev = state_reg.clock_sync[1];

    // A setup cycle makes the next cycle an access cycle
    state_next.access_phase = psel_i && !penable_i;

    // RULE9 restart counting on a selected edge, clear on any other change
    // A selected edge starts from zero, any other change aborts
    if (wake_hit) begin
      state_next.counting = 1'b1;
      state_next.count    = '0;
    end else if (wake_change || wake_done) begin
      state_next.counting = 1'b0;
      state_next.count    = '0;
    end else if (state_reg.counting) begin
      state_next.count = state_reg.count + CNT_W'(1);
    end

    // RULE1 RULE2 RULE3 keyed command enters the delay pipe
    // Shift toward the pin once per slow clock cycle
    state_next.cmd_pipe = {state_reg.cmd_pipe[POWER_OFF_DELAY-2:0], 1'b0};
    if (cmd_wr) begin
      state_next.cmd_pipe[0] = 1'b1;
    end

    // RULE18 output holds until the next command or a wake
    if (state_reg.cmd_pipe[POWER_OFF_DELAY-1]) begin
      state_next.power_off = 1'b1;
    end else if (release_now) begin
      state_next.power_off = 1'b0;
    end

    if (cfg_wr) begin
      // Lane 0: edge select and debounce count
      if (pstrb_i[0]) begin
        state_next.edge_sel = wake_edge_t'(pwdata_i[WAKE_EDGE_LSB +: 2]);
        state_next.debounce = pwdata_i[WAKE_DEBOUNCE_LSB +: DEBOUNCE_W];
      end
      // Lane 2: alarm wake enables
      if (pstrb_i[2]) begin
        state_next.timer_en = pwdata_i[TIMER_WAKE_EN_BIT];
        state_next.clock_en = pwdata_i[CLOCK_WAKE_EN_BIT];
      end
    end
    if (mask_wr) begin
      state_next.irq_mask = pwdata_i[2:0];
    end

    // Status read clears, a same-cycle event still sets
    // The sets come after the clear so no event is lost
    if (status_rd) begin
      state_next.wake_flag  = 1'b0;
      state_next.timer_flag = 1'b0;
      state_next.clock_flag = 1'b0;
    end
    // RULE11 wake input flag
    if (wake_done) begin
      state_next.wake_flag = 1'b1;
    end
    // RULE13 timer alarm flag
    if (timer_hit) begin
      state_next.timer_flag = 1'b1;
    end
    // RULE15 clock alarm flag
    if (clock_hit) begin
      state_next.clock_flag = 1'b1;
    end

    state_next.rdata = 32'h0000_0000;
    if (access && !pwrite_i) begin
      unique case (paddr_i)
        WAKE_CONFIGURATION_OFFSET: state_next.rdata = config_word;
        WAKE_STATUS_OFFSET:        state_next.rdata = status_word;
        IRQ_MASK_OFFSET:           state_next.rdata = {29'h0, state_reg.irq_mask};
        default:                   state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Configuration fields start from the reset word
      state_reg          <= '0;
      state_reg.edge_sel <= wake_edge_t'(WAKE_CONFIG_RESET[WAKE_EDGE_LSB +: 2]);
      state_reg.debounce <= WAKE_CONFIG_RESET[WAKE_DEBOUNCE_LSB +: DEBOUNCE_W];
      state_reg.timer_en <= WAKE_CONFIG_RESET[TIMER_WAKE_EN_BIT];
      state_reg.clock_en <= WAKE_CONFIG_RESET[CLOCK_WAKE_EN_BIT];
    end else begin
      state_reg <= state_next;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready_o        = 1'b1;
  // Unmapped accesses are flagged, writes to them dropped
  assign pslverr_o       = access && !addr_ok;
  // Read data comes from the registered state in the access cycle
  assign prdata_o        = state_reg.access_phase ? read_mux(paddr_i) : state_reg.rdata;
  assign power_off_out_o = state_reg.power_off;
  assign irq_o           = |(flags & state_reg.irq_mask);

  function automatic logic [31:0] read_mux(input logic [11:0] addr);
    logic [31:0] value;
    value = 32'h0000_0000;
    if (addr == WAKE_CONFIGURATION_OFFSET) begin
      value = config_word;
    end else if (addr == WAKE_STATUS_OFFSET) begin
      value = status_word;
    end else if (addr == IRQ_MASK_OFFSET) begin
      value = {29'h0, state_reg.irq_mask};
    end
    return value;
  endfunction

endmodule
`default_nettype wire

// *** testbench/swc_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module swc_partner (
  input  wire logic clk_i,
  input  wire logic power_off_i,
  output logic      wake_o,
  output logic      timer_o,
  output logic      clock_o,
  output logic      supply_on_o
);
  // Converter keeps the main supply on while the pin is low
  assign supply_on_o = !power_off_i;
  initial {clock_o, timer_o, wake_o} = 3'b000;
  task automatic drive(input logic [2:0] v);
    @(posedge clk_i);
    {clock_o, timer_o, wake_o} <= v;
  endtask
endmodule
`default_nettype wire

// *** testbench/swc_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module swc_chk
  import shutdown_wakeup_pkg::*;
#(
  parameter int DEBOUNCE_W = 4
) (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        power_off_out_o,
  input wire logic        irq_o
);
  localparam logic [31:0] CFG_MASK = 32'h0003_0003 | (((32'h1 << DEBOUNCE_W) - 32'h1) << 4);
  logic        acc;
  logic        cmd;
  logic        mapped;
  logic [31:0] cfg_reg;
  logic [2:0]  mask_reg;
  assign acc = psel_i && penable_i && pready_o;
  assign mapped = paddr_i inside {POWER_OFF_COMMAND_OFFSET, WAKE_CONFIGURATION_OFFSET, WAKE_STATUS_OFFSET,
                                  IRQ_MASK_OFFSET};
  assign cmd = acc && pwrite_i && paddr_i == POWER_OFF_COMMAND_OFFSET && pwdata_i[31:24] == POWER_OFF_KEY
               && pwdata_i[0] && pstrb_i[3] && pstrb_i[0];
  // Shadow copies of the writable registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg <= WAKE_CONFIG_RESET;
      mask_reg <= 3'h0;
    end else if (acc && pwrite_i && paddr_i == WAKE_CONFIGURATION_OFFSET) begin
      if (pstrb_i[0]) cfg_reg[7:0] <= pwdata_i[7:0] & CFG_MASK[7:0];
      if (pstrb_i[2]) cfg_reg[23:16] <= pwdata_i[23:16] & CFG_MASK[23:16];
    end else if (acc && pwrite_i && paddr_i == IRQ_MASK_OFFSET && pstrb_i[0]) begin
      mask_reg <= pwdata_i[2:0];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_CMD_DELAY: assert property (cmd |-> ##[2:3] power_off_out_o)
    else $error("power off missing after command");
  AST_CMD_CAUSE: assert property ($rose(power_off_out_o) |-> $past(cmd, 2) || $past(cmd, 3))
    else $error("power off without valid command");
  AST_HOLD_LOW: assert property (!power_off_out_o && !cmd && !$past(cmd) && !$past(cmd, 2) |=> !power_off_out_o)
    else $error("power off rose on its own");
  AST_CFG_READ: assert property (acc && !pwrite_i && paddr_i == WAKE_CONFIGURATION_OFFSET
                                 |-> (prdata_o & CFG_MASK) == cfg_reg)
    else $error("config read back wrong");
  AST_STATUS_BITS: assert property (acc && !pwrite_i && paddr_i == WAKE_STATUS_OFFSET
                                    |-> (prdata_o & ~32'h0003_0001) == 32'h0)
    else $error("status has stray bits");
  AST_UNMAPPED: assert property (acc && !mapped |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not flagged");
  AST_MAPPED: assert property (acc && mapped |-> !pslverr_o)
    else $error("mapped access flagged");
  AST_IRQ_MASK: assert property (mask_reg == 3'h0 |-> !irq_o)
    else $error("interrupt while fully masked");
endmodule
bind shutdown_wakeup_controller swc_chk #(.DEBOUNCE_W(DEBOUNCE_W)) chk_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .power_off_out_o(power_off_out_o), .irq_o(irq_o));
`default_nettype wire

// *** testbench/shutdown_wakeup_controller_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module shutdown_wakeup_controller_test;
  import shutdown_wakeup_pkg::*;
  logic        clk, rstn, psel, pen, pwr, pready, pslverr, wake, talm, calm, poff, irq, rd_err, supply;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic [3:0]  pstrb;
  int          err_total, checks_done;
  shutdown_wakeup_controller uut (.ref_clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .wake_in0_i(wake), .timer_alarm_i(talm), .clock_alarm_i(calm), .power_off_out_o(poff), .irq_o(irq));
  swc_partner far (.clk_i(clk), .power_off_i(poff), .wake_o(wake), .timer_o(talm), .clock_o(calm),
    .supply_on_o(supply));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic rdy;
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge clk);
    pen <= 1'b1;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(posedge clk);
      {rdy, rd_val, rd_err} = {pready, prdata, pslverr};
    end
    {psel, pen} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", n, x, g);
      err_total++;
    end
  endtask
  task automatic t_regs;
    tick(1);
    chk("poff reset", 0, poff);
    apb(1'b0, WAKE_CONFIGURATION_OFFSET, 0, 4'hf);
    chk("cfg reset", WAKE_CONFIG_RESET, rd_val);
    wr(WAKE_STATUS_OFFSET, 32'hffff_ffff);
    apb(1'b0, WAKE_STATUS_OFFSET, 0, 4'hf);
    chk("status ro", 0, rd_val);
    apb(1'b0, 12'h010, 0, 4'hf);
    chk("unmapped err", 1, rd_err);
    wr(WAKE_CONFIGURATION_OFFSET, 32'h0003_00f2);
    apb(1'b0, WAKE_CONFIGURATION_OFFSET, 0, 4'hf);
    chk("cfg rw", 32'h0003_00f2, rd_val);
    apb(1'b1, WAKE_CONFIGURATION_OFFSET, 32'h0000_0001, 4'h4);
    apb(1'b0, WAKE_CONFIGURATION_OFFSET, 0, 4'h0);
    chk("cfg lane2", 32'h0000_00f2, rd_val);
  endtask
  task automatic t_cmd;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 0, i == 0 ? 32'h5a00_0001 : i == 1 ? 32'ha500_0000 : 32'ha500_0001, i == 2 ? 4'h1 : 4'hf);
      tick(4);
      chk("poff refused", 0, poff);
    end
    wr(0, 32'ha500_0001);
    tick(2);
    chk("poff early", 0, poff);
    tick(1);
    chk("poff on", 1, poff);
    chk("supply off", 0, supply);
  endtask
  task automatic t_wake;
    for (int m = 0; m < 4; m++) begin
      far.drive(3'b000);
      tick(40);
      wr(WAKE_CONFIGURATION_OFFSET, 32'h10 | m);
      apb(1'b0, WAKE_STATUS_OFFSET, 0, 4'hf);
      wr(0, 32'ha500_0001);
      tick(4);
      far.drive(3'b001);
      tick(14);
      chk("wake early", 1, poff);
      tick(10);
      chk("wake release", !m[0], poff);
      apb(1'b0, WAKE_STATUS_OFFSET, 0, 4'hf);
      chk("wake flag", m[0], rd_val);
    end
    wr(WAKE_CONFIGURATION_OFFSET, 32'h11);
    far.drive(3'b000);
    tick(40);
    apb(1'b0, WAKE_STATUS_OFFSET, 0, 4'hf);
    wr(0, 32'ha500_0001);
    tick(4);
    far.drive(3'b001);
    tick(8);
    far.drive(3'b000);
    tick(40);
    chk("glitch poff", 1, poff);
  endtask
  task automatic t_alarm;
    for (int i = 0; i < 2; i++) begin
      wr(IRQ_MASK_OFFSET, 0);
      wr(WAKE_CONFIGURATION_OFFSET, i == 0 ? 32'h0001_0000 : 32'h0002_0000);
      apb(1'b0, WAKE_STATUS_OFFSET, 0, 4'hf);
      wr(0, 32'ha500_0001);
      tick(4);
      far.drive(i == 0 ? 3'b100 : 3'b010);
      tick(20);
      chk("alarm off", 1, poff);
      far.drive(3'b110);
      tick(6);
      chk("alarm wake", 0, poff);
      chk("supply on", 1, supply);
      chk("irq masked", 0, irq);
      wr(IRQ_MASK_OFFSET, 7);
      tick(1);
      chk("irq on", 1, irq);
      apb(1'b0, WAKE_STATUS_OFFSET, 0, 4'hf);
      chk("alarm flag", i == 0 ? 32'h0001_0000 : 32'h0002_0000, rd_val);
      tick(1);
      chk("irq clear", 0, irq);
      far.drive(3'b000);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {rstn, psel, pen, pwr, paddr, pwdata, pstrb} = '0;
    err_total = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_cmd;
    t_wake;
    t_alarm;
    results;
  end
  initial begin
    #300000;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
